/* File: src/scb_sdram_cmd_bank.sv */
// Command decode, power states, per-bank state and data masking of a four-bank SDRAM
`default_nettype none
module scb_sdram_cmd_bank
  import scb_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic        i_cke,
  input  wire logic [3:0]  i_dqm,
  input  wire logic [1:0]  i_ba,
  input  wire logic [10:0] i_addr,
  input  wire logic [31:0] i_dq_in,
  input  wire logic [31:0] i_arr_rdata,
  input  wire logic        i_wr_ready,
  output scb_cmd_t         o_cmd,
  output scb_rd_req_t      o_rd_req,
  output logic             o_wr_valid,
  output scb_wbeat_t       o_wr_beat,
  output logic             o_wfifo_ready,
  output logic [31:0]      o_dq_out,
  output logic [3:0]       o_dq_oe,
  output logic [10:0]      o_mode_reg,
  output logic             o_refresh_stb,
  output logic [10:0]      o_refresh_row,
  output scb_dev_e_t       o_dev_state,
  output scb_bank_e_t [3:0] o_bank_state,
  output logic             o_all_idle
);

  scb_cmd_e_t          cmd;
  logic                exec;
  logic                clk_on;
  logic                all_idle;
  logic                start;
  logic                beat;
  logic                burst_end;
  logic                burst_stop;
  logic                sref_tick;

  logic                cke_prev_q;
  scb_dev_e_t          dev_q;
  logic [3:0]          dev_tmr_q;
  scb_bank_e_t [3:0]   bank_q;
  logic [3:0]          bank_tmr_q [NUM_BANKS];
  logic                burst_live_q;
  logic                burst_wr_q;
  logic [1:0]          burst_bank_q;
  logic [COL_W-1:0]    burst_col_q;
  logic [3:0]          burst_left_q;
  logic [10:0]         mode_q;
  logic [10:0]         ref_row_q;
  logic [10:0]         sref_cnt_q;
  logic                refresh_stb_q;
  scb_cmd_t            cmd_q;
  scb_rd_req_t         rd_req_q;
  logic [1:0]          rd_pipe_q;
  logic [3:0]          dqm_p1_q;
  logic [3:0]          dqm_p2_q;
  logic [31:0]         dq_out_q;
  logic [3:0]          dq_oe_q;
  scb_wbeat_t          wbeat;
  logic                wpush;
  logic [$bits(scb_wbeat_t)-1:0] wfifo_out;

  // Inhibit and NOP both fall out of the decode as CMD_NOP
  assign cmd      = scb_decode(i_cs_n, i_ras_n, i_cas_n, i_we_n);
  // This edge counts only if clock enable was high on the previous one
  assign clk_on   = cke_prev_q;
  assign exec     = (dev_q == DEV_RUN) && clk_on;
  assign all_idle = (bank_q[0] == BK_IDLE) && (bank_q[1] == BK_IDLE) &&
                    (bank_q[2] == BK_IDLE) && (bank_q[3] == BK_IDLE);
  assign start    = exec && ((cmd == CMD_RD) || (cmd == CMD_WR)) &&
                    (bank_q[i_ba] inside {BK_ACTIVE, BK_READ, BK_WRITE});
  // Beats are frozen while the clock is suspended
  assign beat      = clk_on && burst_live_q && !start;
  assign burst_end = beat && (burst_left_q == 4'h1);
  assign burst_stop = burst_live_q && (burst_end ||
                      (exec && (cmd == CMD_BST)) || start ||
                      (exec && (cmd == CMD_PRE) &&
                       (i_addr[AP_BIT] || (i_ba == burst_bank_q))));
  assign sref_tick = (dev_q == DEV_SREF) && (sref_cnt_q == 11'h001);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= i_cke;
    end
  end

  // Device power and whole-device operation state
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      dev_q     <= DEV_RUN;
      dev_tmr_q <= 4'h0;
    end else begin
      unique case (dev_q)
        DEV_RUN: begin
          if (cke_prev_q && !i_cke) begin
            if (burst_live_q || start) begin
              dev_q <= DEV_SUSP;
            end else if (all_idle && (cmd == CMD_REF)) begin
              dev_q <= DEV_SREF;
            end else begin
              dev_q <= DEV_PDOWN;
            end
          end else if (exec && all_idle && (cmd == CMD_REF)) begin
            dev_q     <= DEV_BUSY;
            dev_tmr_q <= RC_CYC;
          end else if (exec && all_idle && (cmd == CMD_LMR)) begin
            dev_q     <= DEV_BUSY;
            dev_tmr_q <= MRD_CYC;
          end
        end
        DEV_PDOWN: begin
          if (i_cke) begin
            dev_q <= DEV_RUN;
          end
        end
        DEV_SUSP: begin
          if (i_cke) begin
            dev_q <= DEV_RUN;
          end
        end
        DEV_SREF: begin
          if (i_cke) begin
            dev_q     <= DEV_XSR;
            dev_tmr_q <= XSR_CYC;
          end
        end
        DEV_XSR, DEV_BUSY: begin
          // Commands here are ignored; the controller owes NOPs until the count ends
          if (dev_tmr_q <= 4'h1) begin
            dev_q <= DEV_RUN;
          end else begin
            dev_tmr_q <= dev_tmr_q - 4'h1;
          end
        end
        default: begin
          dev_q <= DEV_RUN;
        end
      endcase
    end
  end

  // Per-bank state; command effects come last so they override timeouts
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_q[b]     <= BK_IDLE;
        bank_tmr_q[b] <= 4'h0;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (bank_tmr_q[b] != 4'h0) begin
          bank_tmr_q[b] <= bank_tmr_q[b] - 4'h1;
        end
        unique case (bank_q[b])
          BK_ACTVING: begin
            if (bank_tmr_q[b] <= 4'h1) begin
              bank_q[b] <= BK_ACTIVE;
            end
          end
          BK_PRECHG: begin
            if (bank_tmr_q[b] <= 4'h1) begin
              bank_q[b] <= BK_IDLE;
            end
          end
          BK_READ, BK_WRITE: begin
            if (burst_stop && (burst_bank_q == 2'(b))) begin
              bank_q[b] <= BK_ACTIVE;
            end
          end
          BK_READ_AP, BK_WRITE_AP: begin
            // An interrupted auto-precharge burst still closes its row
            if (burst_stop && (burst_bank_q == 2'(b))) begin
              bank_q[b]     <= BK_PRECHG;
              bank_tmr_q[b] <= RP_CYC;
            end
          end
          default: begin
          end
        endcase
        if (exec) begin
          unique case (cmd)
            CMD_ACT: begin
              if ((i_ba == 2'(b)) && (bank_q[b] == BK_IDLE)) begin
                bank_q[b]     <= BK_ACTVING;
                bank_tmr_q[b] <= RCD_CYC;
              end
            end
            CMD_RD, CMD_WR: begin
              if (start && (i_ba == 2'(b))) begin
                if (cmd == CMD_RD) begin
                  bank_q[b] <= i_addr[AP_BIT] ? BK_READ_AP : BK_READ;
                end else begin
                  bank_q[b] <= i_addr[AP_BIT] ? BK_WRITE_AP : BK_WRITE;
                end
              end
            end
            CMD_PRE: begin
              // Idle banks are left alone, so a precharge to them is a NOP
              if ((i_addr[AP_BIT] || (i_ba == 2'(b))) &&
                  (bank_q[b] inside {BK_ACTIVE, BK_READ, BK_WRITE})) begin
                bank_q[b]     <= BK_PRECHG;
                bank_tmr_q[b] <= RP_CYC;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Burst engine: one burst live at a time across all banks
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      burst_live_q <= 1'b0;
      burst_wr_q   <= 1'b0;
      burst_bank_q <= 2'h0;
      burst_col_q  <= '0;
      burst_left_q <= 4'h0;
    end else if (start) begin
      burst_live_q <= (BURST_LEN > 4'h1);
      burst_wr_q   <= (cmd == CMD_WR);
      burst_bank_q <= i_ba;
      burst_col_q  <= i_addr[COL_W-1:0] + COL_W'(1);
      burst_left_q <= BURST_LEN - 4'h1;
    end else if (burst_stop) begin
      burst_live_q <= 1'b0;
    end else if (beat) begin
      burst_col_q  <= burst_col_q + COL_W'(1);
      burst_left_q <= burst_left_q - 4'h1;
    end
  end

  // Mode register and decoded command with routed address fields
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mode_q <= MODE_RST;
      cmd_q  <= '0;
    end else begin
      if (exec && all_idle && (cmd == CMD_LMR)) begin
        mode_q <= i_addr;
      end
      cmd_q.valid <= exec && (cmd != CMD_NOP) && (cmd != CMD_REF);
      cmd_q.kind  <= cmd;
      cmd_q.bank  <= i_ba;
      cmd_q.ap    <= i_addr[AP_BIT];
      cmd_q.all   <= (cmd == CMD_PRE) && i_addr[AP_BIT];
      if ((cmd == CMD_RD) || (cmd == CMD_WR)) begin
        cmd_q.addr <= {3'h0, i_addr[COL_W-1:0]};
      end else begin
        cmd_q.addr <= i_addr;
      end
    end
  end

  // Refresh row counter serves both auto and self refresh
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ref_row_q     <= ROW_RST;
      sref_cnt_q    <= SREF_CYC;
      refresh_stb_q <= 1'b0;
    end else begin
      refresh_stb_q <= 1'b0;
      if ((exec && i_cke && all_idle && (cmd == CMD_REF)) || sref_tick) begin
        ref_row_q     <= ref_row_q + 11'h001;
        refresh_stb_q <= 1'b1;
      end
      if ((dev_q != DEV_SREF) || sref_tick) begin
        sref_cnt_q <= SREF_CYC;
      end else begin
        sref_cnt_q <= sref_cnt_q - 11'h001;
      end
    end
  end

  // Read path: masks act on the output two clocks after they are sampled
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rd_req_q  <= '0;
      rd_pipe_q <= 2'h0;
      dqm_p1_q  <= 4'hf;
      dqm_p2_q  <= 4'hf;
      dq_out_q  <= 32'h0000_0000;
      dq_oe_q   <= 4'h0;
    end else begin
      rd_req_q.valid <= (start && (cmd == CMD_RD)) || (beat && !burst_wr_q);
      rd_req_q.bank  <= start ? i_ba : burst_bank_q;
      rd_req_q.col   <= start ? i_addr[COL_W-1:0] : burst_col_q;
      rd_pipe_q      <= {rd_pipe_q[0],
                         (start && (cmd == CMD_RD)) || (beat && !burst_wr_q)};
      dqm_p1_q       <= i_dqm;
      dqm_p2_q       <= dqm_p1_q;
      dq_out_q       <= i_arr_rdata;
      dq_oe_q        <= {4{rd_pipe_q[1]}} & ~dqm_p2_q;
    end
  end

  // Write path: masks gate the beat in the cycle they arrive
  always_comb begin
    wbeat.bank = start ? i_ba : burst_bank_q;
    wbeat.col  = start ? i_addr[COL_W-1:0] : burst_col_q;
    wbeat.be   = ~i_dqm;
    wbeat.data = i_dq_in;
  end
  assign wpush = (start && (cmd == CMD_WR)) || (beat && burst_wr_q);

  // Array side may stall; a full FIFO is flagged so the controller can back off
  scb_fifo #(
    .WIDTH ($bits(scb_wbeat_t)),
    .DEPTH (WFIFO_DEPTH)
  ) u_wfifo (
    .i_ref_clk   (i_ref_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (wpush),
    .o_in_ready  (o_wfifo_ready),
    .i_in_data   (wbeat),
    .o_out_valid (o_wr_valid),
    .i_out_ready (i_wr_ready),
    .o_out_data  (wfifo_out)
  );

  assign o_wr_beat     = scb_wbeat_t'(wfifo_out);
  assign o_cmd         = cmd_q;
  assign o_rd_req      = rd_req_q;
  assign o_dq_out      = dq_out_q;
  assign o_dq_oe       = dq_oe_q;
  assign o_mode_reg    = mode_q;
  assign o_refresh_stb = refresh_stb_q;
  assign o_refresh_row = ref_row_q;
  assign o_dev_state   = dev_q;
  assign o_bank_state  = bank_q;
  assign o_all_idle    = all_idle;

endmodule : scb_sdram_cmd_bank
`default_nettype wire

/* File: src/scb_pkg.sv */
// Shared constants, types and decode function for the SDRAM command and bank state block
`default_nettype none
package scb_pkg;

  localparam int CLK_MHZ = 125;

  // Array timing, in ns, and the derived clock counts (least times round up)
  localparam int T_RCD_NS  = 20;
  localparam int T_RP_NS   = 20;
  localparam int T_RC_NS   = 70;
  localparam int T_MRD_NS  = 16;
  localparam int T_XSR_NS  = 80;
  // Self refresh row interval: 64 ms over 4096 rows, a longest time so it rounds down
  localparam int T_SREF_NS = 15625;

  function automatic int ns_cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_cyc_up

  localparam logic [3:0]  RCD_CYC  = 4'(ns_cyc_up(T_RCD_NS));
  localparam logic [3:0]  RP_CYC   = 4'(ns_cyc_up(T_RP_NS));
  localparam logic [3:0]  RC_CYC   = 4'(ns_cyc_up(T_RC_NS));
  localparam logic [3:0]  MRD_CYC  = 4'(ns_cyc_up(T_MRD_NS));
  localparam logic [3:0]  XSR_CYC  = 4'(ns_cyc_up(T_XSR_NS));
  localparam logic [10:0] SREF_CYC = 11'((T_SREF_NS * CLK_MHZ) / 1000);

  localparam int          NUM_BANKS = 4;
  localparam logic [3:0]  BURST_LEN = 4'h4;
  localparam logic [10:0] MODE_RST  = 11'h000;
  localparam logic [10:0] ROW_RST   = 11'h000;
  localparam int          AP_BIT    = 10;
  localparam int          COL_W     = 8;
  localparam int          WFIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACT = 3'b001,
    CMD_RD  = 3'b010,
    CMD_WR  = 3'b011,
    CMD_BST = 3'b100,
    CMD_PRE = 3'b101,
    CMD_REF = 3'b110,
    CMD_LMR = 3'b111
  } scb_cmd_e_t;

  typedef enum logic [2:0] {
    BK_IDLE    = 3'b000,
    BK_ACTVING = 3'b001,
    BK_ACTIVE  = 3'b010,
    BK_READ    = 3'b011,
    BK_WRITE   = 3'b100,
    BK_READ_AP = 3'b101,
    BK_WRITE_AP = 3'b110,
    BK_PRECHG  = 3'b111
  } scb_bank_e_t;

  typedef enum logic [2:0] {
    DEV_RUN   = 3'b000,
    DEV_PDOWN = 3'b001,
    DEV_SREF  = 3'b010,
    DEV_SUSP  = 3'b011,
    DEV_XSR   = 3'b100,
    DEV_BUSY  = 3'b101
  } scb_dev_e_t;

  typedef struct packed {
    logic        valid;
    scb_cmd_e_t  kind;
    logic [1:0]  bank;
    logic [10:0] addr;
    logic        ap;
    logic        all;
  } scb_cmd_t;

  typedef struct packed {
    logic             valid;
    logic [1:0]       bank;
    logic [COL_W-1:0] col;
  } scb_rd_req_t;

  typedef struct packed {
    logic [1:0]       bank;
    logic [COL_W-1:0] col;
    logic [3:0]       be;
    logic [31:0]      data;
  } scb_wbeat_t;

  // Chip select high masks every other pin into a no-operation
  function automatic scb_cmd_e_t scb_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    if (cs_n) begin
      return CMD_NOP;
    end
    unique case ({ras_n, cas_n, we_n})
      3'b111: return CMD_NOP;
      3'b011: return CMD_ACT;
      3'b101: return CMD_RD;
      3'b100: return CMD_WR;
      3'b110: return CMD_BST;
      3'b010: return CMD_PRE;
      3'b001: return CMD_REF;
      3'b000: return CMD_LMR;
    endcase
  endfunction : scb_decode

endpackage : scb_pkg
`default_nettype wire

/* File: src/scb_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`default_nettype none
module scb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule : scb_fifo
`default_nettype wire

/* File: tb/scb_sdram_cmd_bank_asserts.sv */
// Concurrent checks on the command and bank state block
`default_nettype none
module scb_sdram_cmd_bank_asserts
  import scb_pkg::*;
(
  input wire logic              i_ref_clk,
  input wire logic              i_rstn,
  input wire logic              i_cs_n,
  input wire logic              i_ras_n,
  input wire logic              i_cas_n,
  input wire logic              i_we_n,
  input wire logic              i_cke,
  input wire logic [3:0]        i_dqm,
  input wire logic [1:0]        i_ba,
  input wire logic [10:0]       i_addr,
  input wire scb_cmd_t          o_cmd,
  input wire scb_rd_req_t       o_rd_req,
  input wire logic [3:0]        o_dq_oe,
  input wire logic              o_refresh_stb,
  input wire logic [10:0]       o_refresh_row,
  input wire scb_dev_e_t        o_dev_state,
  input wire scb_bank_e_t [3:0] o_bank_state,
  input wire logic              o_all_idle
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  logic       cke_q;
  logic       tk;
  logic [2:0] rcw;
  // Previous-edge clock enable, cleared by reset like the block's own copy
  always_ff @(posedge i_ref_clk) begin
    cke_q <= i_rstn & i_cke;
  end
  assign rcw = {i_ras_n, i_cas_n, i_we_n};
  assign tk  = (o_dev_state == DEV_RUN) && cke_q && !i_cs_n;
  property p_nop; (i_cs_n || rcw == 3'h7) |=> !o_cmd.valid; endproperty
  a_nop: assert property (p_nop) else $error("pulse after no-operation");
  property p_act; tk && rcw == 3'h3 |=> o_cmd.valid && o_cmd.kind == CMD_ACT
    && o_cmd.bank == $past(i_ba) && o_cmd.addr == $past(i_addr); endproperty
  a_act: assert property (p_act) else $error("activate fields wrong");
  property p_rw; tk && rcw[2:1] == 2'b10 |=> o_cmd.ap == $past(i_addr[10])
    && o_cmd.addr == {3'h0, $past(i_addr[7:0])}; endproperty
  a_rw: assert property (p_rw) else $error("column or precharge flag wrong");
  property p_pre; tk && rcw == 3'h2 |=> o_cmd.all == $past(i_addr[10]); endproperty
  a_pre: assert property (p_pre) else $error("precharge scope wrong");
  property p_ref; tk && rcw == 3'h1 && o_all_idle && i_cke
    |=> o_dev_state == DEV_BUSY && o_refresh_stb; endproperty
  a_ref: assert property (p_ref) else $error("auto refresh not started");
  property p_pdn; o_dev_state == DEV_RUN && cke_q && !i_cke && o_all_idle
    && (i_cs_n || rcw == 3'h7) |=> o_dev_state == DEV_PDOWN; endproperty
  a_pdn: assert property (p_pdn) else $error("power-down not entered");
  property p_wake; (o_dev_state == DEV_PDOWN || o_dev_state == DEV_SUSP) && i_cke
    |=> o_dev_state == DEV_RUN; endproperty
  a_wake: assert property (p_wake) else $error("late wake-up");
  property p_row; o_refresh_row != $past(o_refresh_row)
    |-> o_refresh_stb || $past(o_refresh_stb); endproperty
  a_row: assert property (p_row) else $error("row moved without refresh");
  property p_oe; o_dq_oe == ({4{$past(o_rd_req.valid, 2)}} & ~$past(i_dqm, 3)); endproperty
  a_oe: assert property (p_oe) else $error("read lane enable wrong");
  property p_pidle; tk && rcw == 3'h2 && !i_addr[10] && o_bank_state[i_ba] == BK_IDLE
    |=> o_bank_state[o_cmd.bank] == BK_IDLE; endproperty
  a_pidle: assert property (p_pidle) else $error("idle bank disturbed");
endmodule : scb_sdram_cmd_bank_asserts
bind scb_sdram_cmd_bank scb_sdram_cmd_bank_asserts u_chk (.i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n),
  .i_cke(i_cke), .i_dqm(i_dqm), .i_ba(i_ba), .i_addr(i_addr), .o_cmd(o_cmd),
  .o_rd_req(o_rd_req), .o_dq_oe(o_dq_oe), .o_refresh_stb(o_refresh_stb),
  .o_refresh_row(o_refresh_row), .o_dev_state(o_dev_state), .o_bank_state(o_bank_state),
  .o_all_idle(o_all_idle));
`default_nettype wire

/* File: tb/scb_ctl_model.sv */
// Behavioural memory controller driving the command pins
`default_nettype none
module scb_ctl_model (
  input  wire logic   i_ref_clk,
  output logic        o_cs_n,
  output logic [2:0]  o_rcw,
  output logic        o_cke,
  output logic [3:0]  o_dqm,
  output logic [1:0]  o_ba,
  output logic [10:0] o_addr,
  output logic [31:0] o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_cs_n, o_rcw, o_cke, o_dqm, o_ba, o_addr, o_dq} = {5'h1f, 4'h0, 45'h0};
  end
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a,
                     input logic [3:0] m = 4'h0, input logic [31:0] d = 32'h0);
    @(posedge i_ref_clk);
    #1;
    {o_cs_n, o_rcw, o_ba, o_addr, o_dqm, o_dq} = {1'b0, c, b, a, m, d};
  endtask : cmd
  // Inhibit with garbage on the command lines, nothing holds them
  task automatic nop(input logic [3:0] m, input logic [31:0] d);
    @(posedge i_ref_clk);
    #1;
    {o_cs_n, o_rcw, o_addr, o_dqm, o_dq} = {1'b1, ~o_rcw, ~o_addr, m, d};
  endtask : nop
  task automatic idle(input int n);
    repeat (n) nop(4'h0, ~o_dq);
  endtask : idle
  task automatic set_cke(input logic v);
    o_cke = v;
  endtask : set_cke
endmodule : scb_ctl_model
`default_nettype wire

/* File: tb/scb_sdram_cmd_bank_tb.sv */
// Directed tests of the command and bank state block
`default_nettype none
module scb_sdram_cmd_bank_tb
  import scb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] K_ACT = 3'h3, K_RD = 3'h5, K_WR = 3'h4, K_BST = 3'h6;
  localparam logic [2:0] K_PRE = 3'h2, K_REF = 3'h1, K_LMR = 3'h0;
  logic              clk;
  logic              rstn;
  logic              wr_rdy;
  logic [31:0]       arr;
  logic              cs_n;
  logic [2:0]        rcw;
  logic              cke;
  logic [3:0]        dqm;
  logic [1:0]        ba;
  logic [10:0]       addr;
  logic [31:0]       dq;
  scb_cmd_t          cmd;
  scb_rd_req_t       rdq;
  logic              wv;
  scb_wbeat_t        wb;
  logic              wfr;
  logic [31:0]       dqo;
  logic [3:0]        oe;
  logic [10:0]       mode;
  logic              rstb;
  logic [10:0]       row;
  scb_dev_e_t        dev;
  scb_bank_e_t [3:0] bk;
  logic              idl;
  logic [10:0]       r;
  int                errors;
  int                cmp_count;
  scb_ctl_model pm (.i_ref_clk(clk), .o_cs_n(cs_n), .o_rcw(rcw), .o_cke(cke), .o_dqm(dqm),
    .o_ba(ba), .o_addr(addr), .o_dq(dq));
  scb_sdram_cmd_bank DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_ras_n(rcw[2]),
    .i_cas_n(rcw[1]), .i_we_n(rcw[0]), .i_cke(cke), .i_dqm(dqm), .i_ba(ba), .i_addr(addr),
    .i_dq_in(dq), .i_arr_rdata(arr), .i_wr_ready(wr_rdy), .o_cmd(cmd), .o_rd_req(rdq),
    .o_wr_valid(wv), .o_wr_beat(wb), .o_wfifo_ready(wfr), .o_dq_out(dqo), .o_dq_oe(oe),
    .o_mode_reg(mode), .o_refresh_stb(rstb), .o_refresh_row(row), .o_dev_state(dev),
    .o_bank_state(bk), .o_all_idle(idl));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Array read data changes every cycle so a stale capture shows
  always @(posedge clk) arr <= #1 arr + 32'h1;
  function automatic logic [31:0] wdat(input int k);
    return 32'h03020100 + 32'(k) * 32'h10101010;
  endfunction : wdat
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Bounded wait for the device to come back to idle and running
  task automatic settle(input string nm);
    int i;
    for (i = 0; i < 20 && !(idl === 1'b1 && dev === DEV_RUN); i++) pm.idle(1);
    chk(nm, i < 20, 1'b1);
    $display("test %s done", nm);
  endtask : settle
  initial begin
    #(8 * 20000);
    errors++;
    tally_and_finish();
  end
  initial begin
    {errors, cmp_count, rstn, wr_rdy, arr} = 0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    pm.idle(2);
    pm.cmd(K_LMR, 2'h0, 11'h2a5);
    pm.idle(1);
    chk("mode", mode, 11'h2a5);
    settle("mode");
    pm.cmd(K_ACT, 2'h1, 11'h555);
    pm.cmd(K_PRE, 2'h2, 11'h000);
    chk("act", {cmd.bank, cmd.addr, bk[1]}, {2'h1, 11'h555, BK_ACTVING});
    pm.cmd(K_ACT, 2'h0, 11'h0aa);
    chk("pidle", bk[2], BK_IDLE);
    pm.idle(9);
    chk("active", {bk[1], bk[0]}, {BK_ACTIVE, BK_ACTIVE});
    for (int k = 0; k < 8; k++) begin
      if (k % 4 == 0) pm.cmd(K_WR, 2'h1, {3'h0, 8'hfe + 8'(k)}, 4'(k), wdat(k));
      else pm.nop(4'(k), wdat(k));
      if (k == 1) chk("wrst", bk[1], BK_WRITE);
    end
    pm.idle(1);
    chk("full", wfr, 1'b0);
    wr_rdy = 1'b1;
    for (int k = 0; k < 8; k++) begin
      chk("head", {wv, wb}, {1'b1, 2'h1, 8'hfe + 8'(k), ~4'(k), wdat(k)});
      @(posedge clk);
      #1;
    end
    chk("empty", wv, 1'b0);
    $display("test fifo done");
    pm.cmd(K_RD, 2'h0, 11'h010);
    pm.cmd(K_BST, 2'h3, 11'h000);
    pm.cmd(K_WR, 2'h1, 11'h020);
    chk("bst", bk[0], BK_ACTIVE);
    pm.cmd(K_WR, 2'h1, 11'h030);
    pm.cmd(K_PRE, 2'h1, 11'h000);
    chk("wr2", {bk[1], cmd.addr}, {BK_WRITE, 11'h030});
    pm.idle(1);
    chk("trunc", bk[1], BK_PRECHG);
    pm.cmd(K_RD, 2'h0, 11'h440);
    pm.nop(4'h3, 32'h0);
    chk("rdreq", {rdq.valid, rdq.bank, rdq.col, bk[0]}, {1'b1, 2'h0, 8'h40, BK_READ_AP});
    pm.nop(4'h0, 32'h0);
    pm.nop(4'hc, 32'h0);
    #1 chk("oe", {oe, dqo}, {4'hf, arr - 32'h1});
    @(posedge clk) #2 chk("oemask", oe, 4'hc);
    settle("read");
    pm.cmd(K_ACT, 2'h3, 11'h001);
    pm.cmd(K_ACT, 2'h0, 11'h002);
    pm.idle(6);
    pm.cmd(K_WR, 2'h0, 11'h000);
    pm.nop(4'h0, 32'h0);
    pm.set_cke(1'b0);
    pm.idle(2);
    chk("susp", dev, DEV_SUSP);
    pm.set_cke(1'b1);
    pm.idle(1);
    chk("resume", {dev, bk[0]}, {DEV_RUN, BK_WRITE});
    pm.cmd(K_PRE, 2'h1, 11'h400);
    pm.idle(1);
    chk("pall", {bk[3], bk[0]}, {BK_PRECHG, BK_PRECHG});
    settle("pall");
    pm.set_cke(1'b0);
    pm.idle(2);
    chk("pdn", dev, DEV_PDOWN);
    pm.set_cke(1'b1);
    pm.idle(1);
    chk("pup", {dev, idl}, {DEV_RUN, 1'b1});
    pm.cmd(K_REF, 2'h0, 11'h000);
    // Activate while refreshing, which the device must ignore
    pm.cmd(K_ACT, 2'h2, 11'h000);
    chk("ref", {dev, rstb}, {DEV_BUSY, 1'b1});
    pm.idle(1);
    chk("busy", bk[2], BK_IDLE);
    settle("aref");
    chk("row", row, 11'h001);
    pm.cmd(K_REF, 2'h0, 11'h000);
    pm.set_cke(1'b0);
    pm.idle(5);
    chk("sref", dev, DEV_SREF);
    r = row;
    pm.idle(1953);
    chk("srow", row, r + 11'h1);
    pm.set_cke(1'b1);
    pm.idle(2);
    chk("xsr", dev, DEV_XSR);
    settle("sref");
    tally_and_finish();
  end
endmodule : scb_sdram_cmd_bank_tb
`default_nettype wire
